// ---- avf_regs.sv ----
`timescale 1ns/1ns
`include "avf_map.svh"
module avf_regs import avf_pkg::*; (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic rate_range_select,
  input wire logic clock_fault_in,
  input wire logic overcurrent_fault_in,
  input wire logic output_offset_fault_in,
  input wire logic overtemp_fault_in,
  input wire logic speaker_shutdown_n,
  output logic signed [8:0] right_gain_halfdb,
  output logic right_mute,
  output avf_cfg_s cfg,
  output avf_gain_e analog_gain,
  output logic [5:0] switch_ratio_half,
  output logic double_speed,
  output logic [6:0] overcurrent_limit_pct,
  output logic [3:0] fault_flags
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= 5'h01;
      sync2_reg <= 5'h01;
    end else begin
      sync1_reg <= {clock_fault_in, overcurrent_fault_in, output_offset_fault_in, overtemp_fault_in,
                    speaker_shutdown_n};
      sync2_reg <= sync1_reg;
    end
  end

  logic shutdown_n_s;
  logic [3:0] fault_s;
  assign shutdown_n_s = sync2_reg[0];
  assign fault_s = sync2_reg[4:1];

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] vol_reg;
  logic [7:0] vol_next;
  avf_cfg_s ana_reg;
  avf_cfg_s ana_next;
  logic [1:0] oclim_reg;
  logic [1:0] oclim_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [3:0] flags_now;
  logic [2:0] latched;

  avf_fault_latch u_latch (
    .clock(clock),
    .rstn(rstn),
    .fault_evt({fault_s[`AVF_FLT_OC], fault_s[`AVF_FLT_DC], fault_s[`AVF_FLT_OT]}),
    .shutdown_n(shutdown_n_s),
    .fault_flag(latched)
  );

  always_comb begin
    vol_next = vol_reg;
    ana_next = ana_reg;
    oclim_next = oclim_reg;
    rdata_next = 8'h00;
    rvalid_next = reg_rd;
    // Writes only touch the addressed field; reserved location ignored
    if (reg_wr) begin
      case (reg_addr)
        `AVF_ADDR_VOL_R: vol_next = reg_wdata;
        `AVF_ADDR_ANALOG: ana_next = avf_cfg_s'(reg_wdata);
        `AVF_ADDR_FAULT: oclim_next = reg_wdata[`AVF_OCLIM_HI:`AVF_OCLIM_LO];
        default: vol_next = vol_reg;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `AVF_ADDR_VOL_R: rdata_next = vol_reg;
        `AVF_ADDR_ANALOG: rdata_next = ana_reg;
        `AVF_ADDR_FAULT: rdata_next = {2'h0, oclim_reg, flags_now};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      vol_reg <= `AVF_VOL_RST;
      ana_reg <= avf_cfg_s'(`AVF_ANALOG_RST);
      oclim_reg <= `AVF_OCLIM_RST;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      vol_reg <= vol_next;
      ana_reg <= ana_next;
      oclim_reg <= oclim_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // ****************************************
  // Decoders for the audio path
  // ****************************************
  logic [5:0] mult;
  logic [6:0] pct;
  logic signed [8:0] gain_next;
  logic mute_next;
  logic [5:0] ratio_next;

  always_comb begin
    case (ana_reg.pwm_rate_code)
      3'h0: mult = `AVF_MULT_0;
      3'h1: mult = `AVF_MULT_1;
      3'h2: mult = `AVF_MULT_2;
      3'h3: mult = `AVF_MULT_3;
      3'h4: mult = `AVF_MULT_4;
      3'h5: mult = `AVF_MULT_5;
      3'h6: mult = `AVF_MULT_6;
      default: mult = `AVF_MULT_7;
    endcase
    case (oclim_reg)
      2'h0: pct = `AVF_PCT_0;
      2'h1: pct = `AVF_PCT_1;
      2'h2: pct = `AVF_PCT_2;
      default: pct = `AVF_PCT_3;
    endcase
    // Half-dB units relative to the 0 dB code
    gain_next = $signed({1'b0, vol_reg}) - $signed(`AVF_VOL_ZERO_DB);
    mute_next = vol_reg < `AVF_VOL_FLOOR;
    // Period in half frame units; double speed frames are twice as fast, so halve
    ratio_next = rate_range_select ? mult : 6'(mult << 1);
    flags_now = {fault_s[`AVF_FLT_CLK], latched};
  end

  logic signed [8:0] gain_reg;
  logic mute_reg;
  avf_cfg_s cfg_reg;
  logic [5:0] ratio_reg;
  logic ds_reg;
  logic [6:0] pct_reg;
  logic [3:0] flags_reg;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gain_reg <= 9'h000;
      mute_reg <= 1'b0;
      cfg_reg <= avf_cfg_s'(`AVF_ANALOG_RST);
      ratio_reg <= 6'(`AVF_MULT_5 << 1);
      ds_reg <= 1'b0;
      pct_reg <= `AVF_PCT_0;
      flags_reg <= 4'h0;
    end else begin
      gain_reg <= gain_next;
      mute_reg <= mute_next;
      cfg_reg <= ana_reg;
      ratio_reg <= ratio_next;
      ds_reg <= rate_range_select;
      pct_reg <= pct;
      flags_reg <= flags_now;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign right_gain_halfdb = gain_reg;
  assign right_mute = mute_reg;
  assign cfg = cfg_reg;
  assign analog_gain = avf_gain_e'(cfg_reg.analog_gain_code);
  assign switch_ratio_half = ratio_reg;
  assign double_speed = ds_reg;
  assign overcurrent_limit_pct = pct_reg;
  assign fault_flags = flags_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_vol_write;
    reg_wr && reg_addr == `AVF_ADDR_VOL_R;
  endsequence

  chk_vol_apply: assert property (s_vol_write |=> vol_reg == $past(reg_wdata) ##1 right_gain_halfdb ==
      $signed({1'b0, $past(reg_wdata, 2)}) - $signed(`AVF_VOL_ZERO_DB))
    else $error("volume write not applied");
  chk_gain_scale: assert property (right_gain_halfdb == $signed({1'b0, $past(vol_reg)}) - 9'sd207)
    else $error("volume scale wrong");
  chk_mute_floor: assert property (right_mute == ($past(vol_reg) < 8'h07))
    else $error("mute floor wrong");
  chk_rsvd_ignore: assert property (reg_wr && reg_addr != `AVF_ADDR_VOL_R &&
      reg_addr != `AVF_ADDR_ANALOG && reg_addr != `AVF_ADDR_FAULT |=>
      $stable(vol_reg) && $stable(ana_reg) && $stable(oclim_reg))
    else $error("reserved write changed state");
  chk_mono_mode: assert property (cfg.parallel_mono_select == $past(ana_reg[7]) &&
      cfg.mono_source_channel == $past(ana_reg[1]))
    else $error("mono select wrong");
  chk_gain_code: assert property (analog_gain == avf_gain_e'($past(ana_reg[3:2])))
    else $error("analog gain wrong");
  chk_rate_half: assert property (rate_range_select |=> switch_ratio_half == $past(mult))
    else $error("double speed rate not halved");
  chk_rate_full: assert property (!rate_range_select && ana_reg.pwm_rate_code == 3'h5 |=>
      switch_ratio_half == 6'h20)
    else $error("single speed rate wrong");
  chk_oc_limit: assert property (oclim_reg == 2'h1 |=> overcurrent_limit_pct == 7'h4B)
    else $error("overcurrent limit wrong");
  chk_clk_auto: assert property (!fault_s[3] |=> !fault_flags[3])
    else $error("clock fault not self clearing");
  chk_fault_read: assert property (reg_rd && reg_addr == `AVF_ADDR_FAULT |=> reg_rvalid &&
      reg_rdata == {2'h0, $past(oclim_reg), $past(flags_now)})
    else $error("fault register read wrong");
endmodule

// ---- avf_map.svh ----
`ifndef AVF_MAP_SVH
`define AVF_MAP_SVH
// ****************************************
// Register offsets
// ****************************************
`define AVF_ADDR_VOL_R 8'h05
`define AVF_ADDR_ANALOG 8'h06
`define AVF_ADDR_RSVD 8'h07
`define AVF_ADDR_FAULT 8'h08
// ****************************************
// Reset values and volume coding
// ****************************************
`define AVF_VOL_RST 8'hCF
`define AVF_VOL_ZERO_DB 9'h0CF
`define AVF_VOL_FLOOR 8'h07
`define AVF_ANALOG_RST 8'h51
`define AVF_OCLIM_RST 2'h0
// ****************************************
// Field positions
// ****************************************
`define AVF_OCLIM_HI 5
`define AVF_OCLIM_LO 4
`define AVF_FLT_CLK 3
`define AVF_FLT_OC 2
`define AVF_FLT_DC 1
`define AVF_FLT_OT 0
// ****************************************
// Switching multiples of the frame clock
// ****************************************
`define AVF_MULT_0 6'h06
`define AVF_MULT_1 6'h08
`define AVF_MULT_2 6'h0A
`define AVF_MULT_3 6'h0C
`define AVF_MULT_4 6'h0E
`define AVF_MULT_5 6'h10
`define AVF_MULT_6 6'h14
`define AVF_MULT_7 6'h18
// ****************************************
// Overcurrent threshold percentages
// ****************************************
`define AVF_PCT_0 7'h64
`define AVF_PCT_1 7'h4B
`define AVF_PCT_2 7'h32
`define AVF_PCT_3 7'h19
`endif

// ---- avf_pkg.sv ----
package avf_pkg;
  // Layout matches the analog control register bit for bit
  typedef struct packed {
    logic parallel_mono_select;
    logic [2:0] pwm_rate_code;
    logic [1:0] analog_gain_code;
    logic mono_source_channel;
    logic reserved_bit;
  } avf_cfg_s;

  typedef enum logic [1:0] {
    AVF_GAIN_19P2,
    AVF_GAIN_22P6,
    AVF_GAIN_25P0,
    AVF_GAIN_RSVD
  } avf_gain_e;
endpackage

// ---- avf_fault_latch.sv ----
`timescale 1ns/1ns
module avf_fault_latch import avf_pkg::*; (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [2:0] fault_evt,
  input wire logic shutdown_n,
  output logic [2:0] fault_flag
);
  logic [2:0] flag_reg;
  logic [2:0] flag_next;

  // ****************************************
  // Latching faults, one per bit
  // ****************************************
  // Set wins over clear so an event during shutdown is still reported
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_latch
      always_comb begin
        flag_next[g] = fault_evt[g] | (flag_reg[g] & shutdown_n);
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flag_reg <= 3'h0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign fault_flag = flag_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  chk_latch_hold: assert property (flag_reg[0] && shutdown_n |=> flag_reg[0])
    else $error("latched fault dropped without shutdown");
  chk_latch_set: assert property (fault_evt[1] |=> flag_reg[1])
    else $error("fault event not latched");
endmodule

// ---- avf_host_model.sv ----
`timescale 1ns/1ns
`include "avf_map.svh"
// ****************************************
// Host controller on the register port
// ****************************************
module avf_host_model (
  input wire logic clock,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // Idle bus shows inverted values, so stale data never passes for good
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == `AVF_ADDR_RSVD) return;
    if (a == `AVF_ADDR_ANALOG && d[3:2] == 2'b11) d[3:2] = 2'b10;
    if (a == `AVF_ADDR_ANALOG) d[0] = 1'b1;
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // Bounded wait: a lost answer yields unknown data
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    reg_addr = ~a;
    while (reg_rvalid !== 1'b1 && n < 3) begin
      @(negedge clock);
      n++;
    end
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask
endmodule

// ---- test_avf_regs.sv ----
`timescale 1ns/1ns
`include "avf_map.svh"
module test_avf_regs import avf_pkg::*;;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic reg_wr, reg_rd, reg_rvalid, right_mute, double_speed;
  logic rate_range_select = 1'b0;
  logic [3:0] fin = 4'h0;
  logic speaker_shutdown_n = 1'b1;
  logic signed [8:0] right_gain_halfdb;
  avf_cfg_s cfg;
  avf_gain_e analog_gain;
  logic [5:0] switch_ratio_half;
  logic [6:0] overcurrent_limit_pct;
  logic [3:0] fault_flags;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int mult[8] = '{6, 8, 10, 12, 14, 16, 20, 24};
  int pct[4] = '{100, 75, 50, 25};
  logic [7:0] codes[5] = '{8'hFF, 8'hCF, 8'h07, 8'h06, 8'h00};
  logic [7:0] v;

  avf_host_model u_host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  avf_regs u_dut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .rate_range_select(rate_range_select), .clock_fault_in(fin[3]), .overcurrent_fault_in(fin[2]),
    .output_offset_fault_in(fin[1]), .overtemp_fault_in(fin[0]), .speaker_shutdown_n(speaker_shutdown_n),
    .right_gain_halfdb(right_gain_halfdb), .right_mute(right_mute), .cfg(cfg), .analog_gain(analog_gain),
    .switch_ratio_half(switch_ratio_half), .double_speed(double_speed),
    .overcurrent_limit_pct(overcurrent_limit_pct), .fault_flags(fault_flags));

  // ****************************************
  // Clock, timeout and helpers
  // ****************************************
  initial begin
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clock);
  endtask

  task finish_test;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    wait_n(16);
    rstn = 1'b1;
    wait_n(1);
    check(16'(right_gain_halfdb), 16'h0000);
    check(16'(cfg), 16'h0051);
    check(16'(switch_ratio_half), 16'h0020);
    check(16'(overcurrent_limit_pct), 16'h0064);
    check(16'(right_mute), 16'h0000);
    check(16'(analog_gain), 16'h0000);
    check(16'(double_speed), 16'h0000);
    check(16'(fault_flags), 16'h0000);
    u_host.rd(`AVF_ADDR_VOL_R, rv);
    check(16'(rv), 16'h00CF);
    u_host.rd(`AVF_ADDR_ANALOG, rv);
    check(16'(rv), 16'h0051);
    u_host.rd(`AVF_ADDR_FAULT, rv);
    check(16'(rv), 16'h0000);
    for (int i = 0; i < 5; i++) begin
      u_host.wr(`AVF_ADDR_VOL_R, codes[i]);
      wait_n(1);
      check(16'(right_gain_halfdb), 16'(int'(codes[i]) - 207));
      check(16'(right_mute), 16'(codes[i] < 8'h07));
    end
    for (int i = 0; i < 8; i++) begin
      v = {i[0], i[2:0], 2'(i % 3), i[1], 1'b1};
      u_host.wr(`AVF_ADDR_ANALOG, v);
      wait_n(1);
      check(16'(cfg), 16'(v));
      check(16'(analog_gain), 16'(i % 3));
      check(16'(switch_ratio_half), 16'(2 * mult[i]));
      rate_range_select = 1'b1;
      wait_n(3);
      check(16'(double_speed), 16'h0001);
      check(16'(switch_ratio_half), 16'(mult[i]));
      rate_range_select = 1'b0;
      u_host.rd(`AVF_ADDR_ANALOG, rv);
      check(16'(rv), 16'(v));
    end
    u_host.wr(8'h04, 8'h5A);
    u_host.rd(`AVF_ADDR_VOL_R, rv);
    check(16'(rv), 16'h0000);
    u_host.rd(`AVF_ADDR_ANALOG, rv);
    check(16'(rv), 16'(v));
    for (int k = 0; k < 4; k++) begin
      u_host.wr(`AVF_ADDR_FAULT, {2'b11, 2'(k), 4'hF});
      wait_n(1);
      check(16'(overcurrent_limit_pct), 16'(pct[k]));
      u_host.rd(`AVF_ADDR_FAULT, rv);
      check(16'(rv), 16'(k * 16));
    end
    u_host.rd(8'h09, rv);
    check(16'(rv), 16'h0000);
    fin = 4'h8;
    wait_n(3);
    check(16'(fault_flags), 16'h0008);
    fin = 4'h0;
    wait_n(3);
    check(16'(fault_flags), 16'h0000);
    fin = 4'h7;
    wait_n(4);
    fin = 4'h0;
    wait_n(6);
    check(16'(fault_flags), 16'h0007);
    u_host.rd(`AVF_ADDR_FAULT, rv);
    check(16'(rv), 16'h0037);
    speaker_shutdown_n = 1'b0;
    wait_n(4);
    speaker_shutdown_n = 1'b1;
    wait_n(4);
    check(16'(fault_flags), 16'h0000);
    rstn = 1'b0;
    wait_n(2);
    rstn = 1'b1;
    wait_n(1);
    check(16'(cfg), 16'h0051);
    check(16'(overcurrent_limit_pct), 16'h0064);
    u_host.rd(`AVF_ADDR_VOL_R, rv);
    check(16'(rv), 16'h00CF);
    finish_test();
  end
endmodule
